// File: inc/pcsreg_consts.svh
// Register offsets, field positions and reset values of the PCS/IO config bank.
// Assumes an APB slave with 32-bit data; register index times four is the byte address.
`ifndef PCSREG_CONSTS_SVH
`define PCSREG_CONSTS_SVH

// ****************************************************************
// Register indices
// ****************************************************************
`define PCSREG_IDX_PIN_LOW      12'h457
`define PCSREG_IDX_PIN_HIGH     12'h458
`define PCSREG_IDX_STRAP        12'h45D
`define PCSREG_IDX_CLKSEL       12'h45F
`define PCSREG_IDX_LINKTRN      12'h485
`define PCSREG_IDX_SCRTHR       12'h486
`define PCSREG_IDX_INTERLV      12'h489
`define PCSREG_IDX_JABBER       12'h496
`define PCSREG_IDX_TESTLEN      12'h497
`define PCSREG_IDX_RXFOPT       12'h4A0

// ****************************************************************
// Reset values
// ****************************************************************
`define PCSREG_RST_CLKSEL       16'h000C
`define PCSREG_RST_CLKSEL_STRAP 16'h0003
`define PCSREG_RST_LINKTRN      16'h1078
`define PCSREG_RST_SCRTHR       16'h0A05
`define PCSREG_RST_INTERLV      16'h0001
`define PCSREG_RST_JABBER       16'h044C
`define PCSREG_RST_TESTLEN      16'h01C0
`define PCSREG_RST_RXFOPT       16'h1000

// ****************************************************************
// Writable masks and low pin readback mask
// ****************************************************************
`define PCSREG_WM_CLKSEL        16'hC01F
`define PCSREG_WM_LINKTRN       16'h71FF
`define PCSREG_WM_SCRTHR        16'hFF1F
`define PCSREG_WM_INTERLV       16'h0007
`define PCSREG_WM_JABBER        16'h07FF
`define PCSREG_WM_TESTLEN       16'h03F0
`define PCSREG_WM_RXFOPT        16'hFFFD
`define PCSREG_PIN_LOW_MASK     16'hEFFF

// ****************************************************************
// Field positions and delimiter values
// ****************************************************************
`define PCSREG_SFD_PLAIN        8'hD5
`define PCSREG_SFD_SWAPPED      8'h5D
`define PCSREG_STRAP_RXD3_BIT   8

`endif

// File: inc/pcsreg_pkg.sv
// Types shared by the PCS/IO config bank.
// Assumes nothing of its surroundings.
`default_nettype none
package pcsreg_pkg;
   typedef enum logic [1:0] {
      PCSREG_SRC_DAISY,
      PCSREG_SRC_TXTEST,
      PCSREG_SRC_ANATEST,
      PCSREG_SRC_DIGITAL
   } pcsreg_clk_src_t;

   typedef enum logic [1:0] {
      PCSREG_ORD_PLAIN,
      PCSREG_ORD_BITREV,
      PCSREG_ORD_NIBSWAP,
      PCSREG_ORD_NIBREV
   } pcsreg_byte_order_t;

   typedef enum logic [1:0] {
      PCSREG_CAP_WAIT,
      PCSREG_CAP_TAKE,
      PCSREG_CAP_DONE
   } pcsreg_cap_state_t;
endpackage : pcsreg_pkg
`default_nettype wire

// File: src/pcsreg_bank.sv
// Configuration and status register bank for the PCS and IO of a single-pair PHY.
// Assumes APB on pclk, pin levels arriving asynchronously, straps stable around reset.
//
// Contract
// - Low readback word returns live levels of pins forced to input.
// - Bit 12 of low readback reads zero; others map to fixed pins.
// - High readback low two bits show second/third rx data pins; rest zero.
// - Strap bits 13 and 12 latched only at power-up.
// - Other straps latched at power-up or reset; bit 8 picks the clock-select reset value.
// - Second LED source select resets 11, or 00 when rx data3 strap set.
// - Clock-out source select resets 00, or 11 when rx data3 strap set.
// - Link training enable resets one and gates training start.
// - Bit 14 forces slave equalizer first phase done.
// - Bit 13 disables descrambler lock check during gap.
// - Nine-bit idle count for scrambler lock, reset 1111000b.
// - Eight-bit non-idle count for unlock, reset 1010b.
// - Five-bit error count for remote receiver status, reset 101b.
// - Interleave bit 2 forces transmit interleave.
// - Interleave bit 1 enables transmit interleave only when detected on receive.
// - Interleave bit 0 enables receive interleave detection, reset one.
// - Eleven-bit jabber timeout in microseconds, reset 10001001100b.
// - Test mode 1 sends two plus twice count symbols, reset 11100b.
// - Two-bit field picks receive byte ordering.
// - Delimiter select picks 0xD5 or 0x5D.
`timescale 1ns/1ps
`default_nettype none
`include "pcsreg_consts.svh"

module pcsreg_bank (
   // Clock, reset, enable
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   // Power-up indication (high for first cycles after power-on)
   input  wire logic        poweron_pulse,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [15:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Pin levels and input-force indications
   input  wire logic [15:0] pin_level_low,
   input  wire logic [15:0] pin_forced_in_low,
   input  wire logic [1:0]  pin_level_high,
   input  wire logic [1:0]  pin_forced_in_high,
   // Strap pins
   input  wire logic        second_led_poweron_strap,
   input  wire logic        rxdata3_poweron_strap,
   input  wire logic [9:0]  strap_pins,
   // Rx interleave detected by the PCS
   input  wire logic        rx_interleave_seen,
   // Configuration out
   output logic [1:0]       led_pin_src,
   output logic [1:0]       clkout_pin_src,
   output logic             analog_test_line_pick,
   output logic             training_start_en,
   output logic             slave_first_phase_override,
   output logic             gap_lock_check_off,
   output logic [8:0]       lock_idle_count,
   output logic [7:0]       unlock_error_count,
   output logic [4:0]       remote_status_error_count,
   output logic             tx_interleave_on,
   output logic             rx_interleave_detect_en,
   output logic [10:0]      jabber_timeout_us,
   output logic [7:0]       pattern_one_length,
   output logic [1:0]       receive_frame_filter_order,
   output logic [7:0]       receive_frame_filter_sfd,
   output logic             enhanced_rx_en
);

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   logic [15:0] lvl_lo_s1_ff, lvl_lo_ff, frc_lo_s1_ff, frc_lo_ff;
   logic [1:0]  lvl_hi_s1_ff, lvl_hi_ff, frc_hi_s1_ff, frc_hi_ff;
   logic [11:0] strap_s1_ff, strap_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lvl_lo_s1_ff <= 16'h0000;
         lvl_lo_ff    <= 16'h0000;
         frc_lo_s1_ff <= 16'h0000;
         frc_lo_ff    <= 16'h0000;
         lvl_hi_s1_ff <= 2'h0;
         lvl_hi_ff    <= 2'h0;
         frc_hi_s1_ff <= 2'h0;
         frc_hi_ff    <= 2'h0;
      end else if (clk_en) begin
         lvl_lo_s1_ff <= pin_level_low;
         lvl_lo_ff    <= lvl_lo_s1_ff;
         frc_lo_s1_ff <= pin_forced_in_low;
         frc_lo_ff    <= frc_lo_s1_ff;
         lvl_hi_s1_ff <= pin_level_high;
         lvl_hi_ff    <= lvl_hi_s1_ff;
         frc_hi_s1_ff <= pin_forced_in_high;
         frc_hi_ff    <= frc_hi_s1_ff;
      end
   end

   // Straps fill during reset so the capture after release sees settled levels
   always_ff @(posedge pclk) begin
      if (clk_en) begin
         strap_s1_ff <= {second_led_poweron_strap, rxdata3_poweron_strap, strap_pins};
         strap_ff    <= strap_s1_ff;
      end
   end

   // ****************************************************************
   // Pin readback
   // ****************************************************************
   logic [15:0] pin_low_ff;
   logic [1:0]  pin_high_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_low_ff  <= 16'h0000;
         pin_high_ff <= 2'h0;
      end else if (clk_en) begin
         pin_low_ff  <= lvl_lo_ff & frc_lo_ff & `PCSREG_PIN_LOW_MASK;
         pin_high_ff <= lvl_hi_ff & frc_hi_ff;
      end
   end

   // ****************************************************************
   // Strap capture: waits two cycles for the synchroniser to fill
   // ****************************************************************
   pcsreg_pkg::pcsreg_cap_state_t cap_st_ff;
   logic        por_seen_ff;
   logic [1:0]  por_strap_ff;
   logic [9:0]  rst_strap_ff;
   logic        cfg_loaded_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_st_ff <= pcsreg_pkg::PCSREG_CAP_WAIT;
      end else if (clk_en) begin
         unique case (cap_st_ff)
            pcsreg_pkg::PCSREG_CAP_WAIT: cap_st_ff <= pcsreg_pkg::PCSREG_CAP_TAKE;
            pcsreg_pkg::PCSREG_CAP_TAKE: cap_st_ff <= pcsreg_pkg::PCSREG_CAP_DONE;
            pcsreg_pkg::PCSREG_CAP_DONE: cap_st_ff <= pcsreg_pkg::PCSREG_CAP_DONE;
            default:                     cap_st_ff <= pcsreg_pkg::PCSREG_CAP_WAIT;
         endcase
      end
   end

   wire cap_now = (cap_st_ff == pcsreg_pkg::PCSREG_CAP_TAKE);

   // Power-up straps keep their value across ordinary resets
   always_ff @(posedge pclk) begin
      if (clk_en && cap_now && poweron_pulse) begin
         por_strap_ff <= strap_ff[11:10];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_strap_ff <= 10'h000;
      end else if (clk_en && cap_now) begin
         rst_strap_ff <= strap_ff[9:0];
      end
   end

   wire rxdata3_reset_strap = rst_strap_ff[`PCSREG_STRAP_RXD3_BIT];

   // ****************************************************************
   // APB decode
   // ****************************************************************
   wire [13:0] idx    = paddr[15:2];
   wire        wr_acc = psel && penable && pwrite && clk_en;
   logic       hit;

   always_comb begin
      unique case (idx)
         {2'h0, `PCSREG_IDX_PIN_LOW}, {2'h0, `PCSREG_IDX_PIN_HIGH},
         {2'h0, `PCSREG_IDX_STRAP},   {2'h0, `PCSREG_IDX_CLKSEL},
         {2'h0, `PCSREG_IDX_LINKTRN}, {2'h0, `PCSREG_IDX_SCRTHR},
         {2'h0, `PCSREG_IDX_INTERLV}, {2'h0, `PCSREG_IDX_JABBER},
         {2'h0, `PCSREG_IDX_TESTLEN}, {2'h0, `PCSREG_IDX_RXFOPT}: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end

   // ****************************************************************
   // Writable registers
   // ****************************************************************
   logic [15:0] clksel_ff, linktrn_ff, scrthr_ff, interlv_ff;
   logic [15:0] jabber_ff, testlen_ff, rxfopt_ff;

   function automatic logic [15:0] merge(input logic [15:0] old_v, input logic [15:0] mask);
      merge = (old_v & ~mask) | (pwdata[15:0] & mask);
   endfunction : merge

   // Clock-select reset value follows the rx data3 strap once captured
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clksel_ff     <= `PCSREG_RST_CLKSEL;
         cfg_loaded_ff <= 1'b0;
      end else if (clk_en) begin
         if (cap_st_ff == pcsreg_pkg::PCSREG_CAP_DONE && !cfg_loaded_ff) begin
            cfg_loaded_ff <= 1'b1;
            if (rxdata3_reset_strap) begin
               clksel_ff <= `PCSREG_RST_CLKSEL_STRAP;
            end
         end else if (wr_acc && idx == {2'h0, `PCSREG_IDX_CLKSEL}) begin
            clksel_ff <= merge(clksel_ff, `PCSREG_WM_CLKSEL);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         linktrn_ff <= `PCSREG_RST_LINKTRN;
         scrthr_ff  <= `PCSREG_RST_SCRTHR;
         interlv_ff <= `PCSREG_RST_INTERLV;
         jabber_ff  <= `PCSREG_RST_JABBER;
         testlen_ff <= `PCSREG_RST_TESTLEN;
         rxfopt_ff  <= `PCSREG_RST_RXFOPT;
      end else if (wr_acc) begin
         unique case (idx)
            {2'h0, `PCSREG_IDX_LINKTRN}: linktrn_ff <= merge(linktrn_ff, `PCSREG_WM_LINKTRN);
            {2'h0, `PCSREG_IDX_SCRTHR}:  scrthr_ff  <= merge(scrthr_ff, `PCSREG_WM_SCRTHR);
            {2'h0, `PCSREG_IDX_INTERLV}: interlv_ff <= merge(interlv_ff, `PCSREG_WM_INTERLV);
            {2'h0, `PCSREG_IDX_JABBER}:  jabber_ff  <= merge(jabber_ff, `PCSREG_WM_JABBER);
            {2'h0, `PCSREG_IDX_TESTLEN}: testlen_ff <= merge(testlen_ff, `PCSREG_WM_TESTLEN);
            {2'h0, `PCSREG_IDX_RXFOPT}:  rxfopt_ff  <= merge(rxfopt_ff, `PCSREG_WM_RXFOPT);
            default: ;
         endcase
      end
   end

   // ****************************************************************
   // APB read and answer: one wait-free access phase
   // ****************************************************************
   logic [15:0] rd_val;

   always_comb begin
      rd_val = 16'h0000;
      unique case (idx)
         {2'h0, `PCSREG_IDX_PIN_LOW}:  rd_val = pin_low_ff;
         {2'h0, `PCSREG_IDX_PIN_HIGH}: rd_val = {14'h0000, pin_high_ff};
         {2'h0, `PCSREG_IDX_STRAP}:    rd_val = {2'h0, por_strap_ff, 2'h0, rst_strap_ff};
         {2'h0, `PCSREG_IDX_CLKSEL}:   rd_val = clksel_ff;
         {2'h0, `PCSREG_IDX_LINKTRN}:  rd_val = linktrn_ff;
         {2'h0, `PCSREG_IDX_SCRTHR}:   rd_val = scrthr_ff;
         {2'h0, `PCSREG_IDX_INTERLV}:  rd_val = interlv_ff;
         {2'h0, `PCSREG_IDX_JABBER}:   rd_val = jabber_ff;
         {2'h0, `PCSREG_IDX_TESTLEN}:  rd_val = testlen_ff;
         {2'h0, `PCSREG_IDX_RXFOPT}:   rd_val = rxfopt_ff;
         default:                      rd_val = 16'h0000;
      endcase
   end

   // Answer registered in setup cycle so pready is high in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (clk_en) begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !hit;
         if (psel && !penable && !pwrite) begin
            prdata <= {16'h0000, rd_val};
         end
      end
   end

   // ****************************************************************
   // Configuration outputs
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         led_pin_src                <= 2'h3;
         clkout_pin_src             <= 2'h0;
         analog_test_line_pick      <= 1'b0;
         training_start_en          <= 1'b0;
         slave_first_phase_override <= 1'b0;
         gap_lock_check_off         <= 1'b0;
         lock_idle_count            <= 9'h000;
         unlock_error_count         <= 8'h00;
         remote_status_error_count  <= 5'h00;
         tx_interleave_on           <= 1'b0;
         rx_interleave_detect_en    <= 1'b0;
         jabber_timeout_us          <= 11'h000;
         pattern_one_length         <= 8'h00;
         receive_frame_filter_order <= 2'h0;
         receive_frame_filter_sfd   <= `PCSREG_SFD_PLAIN;
         enhanced_rx_en             <= 1'b0;
      end else if (clk_en) begin
         led_pin_src                <= clksel_ff[3:2];
         clkout_pin_src             <= clksel_ff[1:0];
         analog_test_line_pick      <= clksel_ff[4];
         training_start_en          <= linktrn_ff[12] && cfg_loaded_ff;
         slave_first_phase_override <= linktrn_ff[14];
         gap_lock_check_off         <= linktrn_ff[13];
         lock_idle_count            <= linktrn_ff[8:0];
         unlock_error_count         <= scrthr_ff[15:8];
         remote_status_error_count  <= scrthr_ff[4:0];
         tx_interleave_on           <= interlv_ff[2] || (interlv_ff[1] && rx_interleave_seen);
         rx_interleave_detect_en    <= interlv_ff[0];
         jabber_timeout_us          <= jabber_ff[10:0];
         pattern_one_length         <= 8'h02 + {1'b0, testlen_ff[9:4], 1'b0};
         receive_frame_filter_order <= rxfopt_ff[15:14];
         receive_frame_filter_sfd   <= rxfopt_ff[13] ? `PCSREG_SFD_SWAPPED : `PCSREG_SFD_PLAIN;
         enhanced_rx_en             <= rxfopt_ff[7];
      end
   end

endmodule : pcsreg_bank
`default_nettype wire

// File: tb/pcsreg_bank_sva.sv
// Checker for the PCS/IO config bank: APB answers and configuration outputs.
// Assumes it is bound to pcsreg_bank and that the master keeps APB order.
`timescale 1ns/1ps
`default_nettype none
`include "pcsreg_consts.svh"
module pcsreg_bank_sva (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Configuration
   input wire logic        rx_interleave_seen,
   input wire logic        training_start_en,
   input wire logic        tx_interleave_on,
   input wire logic [10:0] jabber_timeout_us,
   input wire logic [7:0]  pattern_one_length,
   input wire logic [7:0]  receive_frame_filter_sfd
);
   // ****************************************************************
   // Decode and bits that must read zero (all of them when unmapped)
   // ****************************************************************
   logic [13:0] idx;
   logic        wr;
   logic [15:0] zmask;
   assign idx = paddr[15:2];
   assign wr  = psel && penable && pready && pwrite;
   always_comb begin
      case (idx)
         `PCSREG_IDX_PIN_LOW:  zmask = ~`PCSREG_PIN_LOW_MASK;
         `PCSREG_IDX_PIN_HIGH: zmask = 16'hFFFC;
         `PCSREG_IDX_STRAP:    zmask = 16'hCC00;
         `PCSREG_IDX_CLKSEL:   zmask = ~`PCSREG_WM_CLKSEL;
         `PCSREG_IDX_LINKTRN:  zmask = ~`PCSREG_WM_LINKTRN;
         `PCSREG_IDX_SCRTHR:   zmask = ~`PCSREG_WM_SCRTHR;
         `PCSREG_IDX_INTERLV:  zmask = ~`PCSREG_WM_INTERLV;
         `PCSREG_IDX_JABBER:   zmask = ~`PCSREG_WM_JABBER;
         `PCSREG_IDX_TESTLEN:  zmask = ~`PCSREG_WM_TESTLEN;
         `PCSREG_IDX_RXFOPT:   zmask = ~`PCSREG_WM_RXFOPT;
         default:              zmask = 16'hFFFF;
      endcase
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_train;
      logic v;
      (wr && idx == `PCSREG_IDX_LINKTRN, v = pwdata[12]) |-> ##2 training_start_en == v;
   endproperty
   property p_txil;
      logic [2:0] v;
      (wr && idx == `PCSREG_IDX_INTERLV, v = pwdata[2:0])
         |-> ##2 tx_interleave_on == (v[2] | (v[1] & rx_interleave_seen));
   endproperty
   property p_jab;
      logic [10:0] v;
      (wr && idx == `PCSREG_IDX_JABBER, v = pwdata[10:0]) |-> ##2 jabber_timeout_us == v;
   endproperty
   property p_pat;
      logic [5:0] v;
      (wr && idx == `PCSREG_IDX_TESTLEN, v = pwdata[9:4])
         |-> ##2 pattern_one_length == 8'h02 + {1'b0, v, 1'b0};
   endproperty
   property p_sfd;
      logic v;
      (wr && idx == `PCSREG_IDX_RXFOPT, v = pwdata[13])
         |-> ##2 receive_frame_filter_sfd == (v ? `PCSREG_SFD_SWAPPED : `PCSREG_SFD_PLAIN);
   endproperty

   AST_ZERO_WAIT: assert property (psel && !penable |=> pready)
      else $error("access phase without ready");
   AST_READ_ZERO: assert property (
      pready && !pwrite |-> (prdata & {16'hFFFF, zmask}) == 32'h0000_0000)
      else $error("reserved or unmapped bits read nonzero");
   AST_UNMAPPED_ERR: assert property (pready |-> pslverr == (zmask == 16'hFFFF))
      else $error("error response does not match decode");
   AST_TRAIN_EN: assert property (p_train)
      else $error("training enable not following write");
   AST_TX_IL: assert property (p_txil)
      else $error("transmit interleave wrong");
   AST_JABBER: assert property (p_jab)
      else $error("jabber timeout not loaded");
   AST_PATTERN: assert property (p_pat)
      else $error("pattern length wrong");
   AST_SFD: assert property (p_sfd)
      else $error("delimiter value wrong");

   COV_ERR: cover property (pready && pslverr);
   COV_RXF_WR: cover property (wr && idx == `PCSREG_IDX_RXFOPT);
   COV_PIN_RD: cover property (pready && !pwrite && idx == `PCSREG_IDX_PIN_LOW);
endmodule : pcsreg_bank_sva

bind pcsreg_bank pcsreg_bank_sva u_sva (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .rx_interleave_seen(rx_interleave_seen), .training_start_en(training_start_en),
   .tx_interleave_on(tx_interleave_on), .jabber_timeout_us(jabber_timeout_us),
   .pattern_one_length(pattern_one_length), .receive_frame_filter_sfd(receive_frame_filter_sfd)
);
`default_nettype wire

// File: tb/testbench.sv
// Self-checking testbench for the PCS/IO config bank.
// Assumes zero-wait APB answers and straps held steady around each reset.
`timescale 1ns/1ps
`default_nettype none
`include "pcsreg_consts.svh"
module testbench;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        clk_en = 1'b1;
   logic        pwr_on = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [15:0] lvl_lo = 16'h0000;
   logic [15:0] frc_lo = 16'h0000;
   logic [1:0]  lvl_hi = 2'h0;
   logic [1:0]  frc_hi = 2'h0;
   logic        led_por = 1'b1;
   logic        rxd3_por = 1'b0;
   logic [1:0]  por_cap;
   logic [9:0]  straps = 10'h2A5;
   logic        il_seen = 1'b0;
   wire logic [61:0] outs;
   integer      seed = 32'hD804;
   int          n_fail = 0;
   int          samples_checked = 0;
   logic [11:0] idx_t [10];
   logic [15:0] wm_t [10];
   logic [15:0] ev [10];
   logic [31:0] rd;
   logic        er;
   logic [15:0] d;
   int          k;

   always #2.5 pclk = ~pclk;

   pcsreg_bank dut (
      .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .poweron_pulse(pwr_on),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pin_level_low(lvl_lo), .pin_forced_in_low(frc_lo), .pin_level_high(lvl_hi),
      .pin_forced_in_high(frc_hi), .second_led_poweron_strap(led_por),
      .rxdata3_poweron_strap(rxd3_por), .strap_pins(straps), .rx_interleave_seen(il_seen),
      .led_pin_src(outs[60:59]), .clkout_pin_src(outs[58:57]),
      .analog_test_line_pick(outs[56]), .training_start_en(outs[55]),
      .slave_first_phase_override(outs[54]), .gap_lock_check_off(outs[53]),
      .lock_idle_count(outs[52:44]), .unlock_error_count(outs[43:36]),
      .remote_status_error_count(outs[35:31]), .tx_interleave_on(outs[30]),
      .rx_interleave_detect_en(outs[29]), .jabber_timeout_us(outs[28:18]),
      .pattern_one_length({outs[61], outs[17:11]}), .receive_frame_filter_order(outs[10:9]),
      .receive_frame_filter_sfd(outs[8:1]), .enhanced_rx_en(outs[0])
   );

   // ****************************************************************
   // Expectations, bus cycles and comparison
   // ****************************************************************
   function automatic logic [61:0] exp_outs(input logic seen);
      logic [7:0] n;
      n = 8'h02 + {1'b0, ev[8][9:4], 1'b0};
      return {n[7], ev[3][3:2], ev[3][1:0], ev[3][4], ev[4][12], ev[4][14], ev[4][13], ev[4][8:0],
              ev[5][15:8], ev[5][4:0], ev[6][2] | (ev[6][1] & seen), ev[6][0], ev[7][10:0],
              n[6:0], ev[9][15:14],
              (ev[9][13] ? `PCSREG_SFD_SWAPPED : `PCSREG_SFD_PLAIN), ev[9][7]};
   endfunction : exp_outs

   task automatic init_exp();
      ev = '{lvl_lo & frc_lo & `PCSREG_PIN_LOW_MASK, {14'h0000, lvl_hi & frc_hi},
             {2'b00, por_cap, 2'b00, straps},
             (straps[8] ? `PCSREG_RST_CLKSEL_STRAP : `PCSREG_RST_CLKSEL), `PCSREG_RST_LINKTRN,
             `PCSREG_RST_SCRTHR, `PCSREG_RST_INTERLV, `PCSREG_RST_JABBER,
             `PCSREG_RST_TESTLEN, `PCSREG_RST_RXFOPT};
   endtask : init_exp

   task automatic chk_val(input logic [63:0] got, input logic [63:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk_val

   task automatic apb(input logic w, input logic [11:0] ix, input logic [15:0] dat);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= {2'b00, ix, 2'b00};
      pwdata  <= {16'h0000, dat};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      chk_val(pready, 1'b1, "ready");
      rd      = prdata;
      er      = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic read_all(input string what);
      for (int i = 0; i < 10; i++) begin
         apb(1'b0, idx_t[i], 16'h0000);
         chk_val(rd, {16'h0000, ev[i]}, what);
         chk_val(er, 1'b0, what);
      end
      chk_val(outs, exp_outs(il_seen), what);
      $display("test %s done", what);
   endtask : read_all

   task automatic wr_chk(input int i, input logic [15:0] dat);
      il_seen <= 1'($random(seed));
      apb(1'b1, idx_t[i], dat);
      ev[i] = (ev[i] & ~wm_t[i]) | (dat & wm_t[i]);
      chk_val(er, 1'b0, "write");
      repeat (3) @(posedge pclk);
      apb(1'b0, idx_t[i], 16'h0000);
      chk_val(rd, {16'h0000, ev[i]}, "readback");
      chk_val(outs, exp_outs(il_seen), "outputs");
   endtask : wr_chk

   task automatic do_reset();
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
      init_exp();
   endtask : do_reset

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      $display("ERROR t=%0t watchdog expired", $time);
      tally_and_finish();
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      idx_t = '{`PCSREG_IDX_PIN_LOW, `PCSREG_IDX_PIN_HIGH, `PCSREG_IDX_STRAP, `PCSREG_IDX_CLKSEL,
                `PCSREG_IDX_LINKTRN, `PCSREG_IDX_SCRTHR, `PCSREG_IDX_INTERLV,
                `PCSREG_IDX_JABBER, `PCSREG_IDX_TESTLEN, `PCSREG_IDX_RXFOPT};
      wm_t  = '{16'h0000, 16'h0000, 16'h0000, `PCSREG_WM_CLKSEL, `PCSREG_WM_LINKTRN,
                `PCSREG_WM_SCRTHR, `PCSREG_WM_INTERLV, `PCSREG_WM_JABBER,
                `PCSREG_WM_TESTLEN, `PCSREG_WM_RXFOPT};
      por_cap = {led_por, rxd3_por};
      do_reset();
      read_all("reset values");
      for (int p = 0; p < 3; p++) begin
         lvl_lo <= (p == 0) ? 16'hFFFF : 16'($random(seed));
         frc_lo <= (p == 0) ? 16'hFFFF : 16'($random(seed));
         lvl_hi <= (p == 0) ? 2'h3 : 2'($random(seed));
         frc_hi <= (p == 0) ? 2'h3 : 2'($random(seed));
         repeat (6) @(posedge pclk);
         init_exp();
         read_all("pin readback");
      end
      for (int c = 0; c < 4; c++) begin
         wr_chk(3, {11'h000, 1'(c), 2'(c), 2'(3 - c)});
         wr_chk(9, {2'(c), 1'(c), 13'h0080});
         wr_chk(6, 16'(c + 2));
      end
      $display("test modes done");
      for (int w = 0; w < 60; w++) begin
         k = (w < 10) ? w : int'($unsigned($random(seed)) % 10);
         d = (w < 10) ? 16'hFFFF : 16'($random(seed));
         wr_chk(k, d);
      end
      $display("test random writes done");
      apb(1'b1, 12'h459, 16'hFFFF);
      chk_val(er, 1'b1, "unmapped write");
      apb(1'b0, 12'h459, 16'h0000);
      chk_val({er, rd}, {1'b1, 32'h0000_0000}, "unmapped read");
      read_all("after unmapped");
      straps   <= 10'h35A;
      pwr_on   <= 1'b0;
      led_por  <= 1'b0;
      rxd3_por <= 1'b1;
      do_reset();
      read_all("strap reset");
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
